/* design/spims_port.sv */
// full-duplex serial port acting as master or slave over four wires
// How it works
// [R1] every byte travels most significant bit first
// [R2] master drives data-out from shift register top
// [R3] slave data-out released when disabled or unselected
// [R4] 3-wire slave always drives data-out from top
// [R5] unselected 4-wire slave ignores serial clock edges
// [R6] mode 00: 3-wire, select unused, always selected
// [R7] mode 01: select is input, low selects
// [R8] multi-master select fall clears enables, flags fault
// [R9] mode fault requests interrupt when enabled
// [R10] software alone re-enables after a mode fault
// [R11] mode 1x: select output follows lower bit
// [R12] software uses select output only as master; the port drives it in modes 1x whenever enabled
// [R13] select pin unused only in 3-wire mode
// [R14] reset mode field is 01, multi-master
// [R15] master enable makes the port the initiator
// [R16] data write fills buffer, starts when idle
// [R17] master shifts data while generating serial clock
// [R18] transfer done flag set per byte, interrupts
// [R19] received byte goes to receive buffer
// [R20] eight counted bits complete a byte
// [R21] phase picks latch edge, polarity idle level
// [R22] master samples input one clock before change
// [R23] reset clears flags, buffers, disables, releases lines
`include "spims_defines.svh"
`default_nettype none
module spims_port
  import spims_pkg::*;
#(
  parameter int HALF_DIV = `SPIMS_HALF_DIV
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // control write: loads the enables, mode, phase and polarity at once; irqEnable acts directly
  input  wire logic                  ctlWrite,
  input  wire logic                  ctlMasterEnable,
  input  wire logic                  ctlPortEnable,
  input  wire spims_pkg::spims_mode_t ctlSelectMode,
  input  wire logic                  ctlClockPhase,
  input  wire logic                  ctlClockPolarity,
  input  wire logic                  irqEnable,
  // data register
  input  wire logic                  dataWrite,
  input  wire spims_pkg::spims_byte_t dataIn,
  input  wire logic                  dataRead,
  output logic [7:0]                 rxData,
  // flag clears, one-cycle pulses
  input  wire logic                  clrTransferDone,
  input  wire logic                  clrModeFault,
  input  wire logic                  clrWriteCollision,
  input  wire logic                  clrRxOverrun,
  // status
  output logic                       masterEnableBit,
  output logic                       portEnableBit,
  output logic [1:0]                 selectModeField,
  output logic                       transferDoneFlag,
  output logic                       modeFaultFlag,
  output logic                       writeCollisionFlag,
  output logic                       rxOverrunFlag,
  output logic                       busy,
  output logic                       irqReq,
  // serial pins
  input  wire logic                  sckIn,
  output logic                       sckOut,
  output logic                       sckOe,
  input  wire logic                  mosiIn,
  output logic                       mosiOut,
  output logic                       mosiOe,
  input  wire logic                  misoIn,
  output logic                       misoOut,
  output logic                       misoOe,
  input  wire logic                  selIn_n,
  output logic                       selOut_n,
  output logic                       selOe,
  output logic                       selPinMapped
);
  import spims_pkg::*;

  localparam int DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

  spims_lnk_if lnk ();

  // control and status state
  logic        master_enable_bit_ff;
  logic        portEn_ff;
  spims_mode_t mode_ff;
  logic        phase_ff;
  logic        pol_ff;
  logic        done_ff;
  logic        mode_fault_flag_ff;
  logic        wcol_ff;
  logic        ovrn_ff;
  // buffers
  spims_byte_t txBuf_ff;
  logic        txFull_ff;
  spims_byte_t rxBuf_ff;
  logic        rxFull_ff;
  spims_byte_t slvTx_ff;
  // master sequencer
  spims_mst_t  mst_ff;
  spims_byte_t shift_ff;
  logic [4:0]  half_ff;
  logic [DIV_W-1:0] div_ff;
  logic        sckTgl_ff;
  // synchronisers
  logic        selMeta_ff;
  logic        selSync_ff;
  logic        selPrev_ff;
  logic        misoMeta_ff;
  logic        misoSync_ff;
  logic        tglMeta_ff;
  logic        tglSync_ff;
  logic        tglPrev_ff;

  logic        isMaster;
  logic        isSlave;
  logic        slvSelected;
  logic        selFall;
  logic        modeFault;
  logic        mstStart;
  logic        mstFinish;
  logic        halfEnd;
  logic [4:0]  kIdx;
  logic        slvDone;
  logic        byteDone;
  spims_byte_t doneByte;
  logic        txTake;

  assign isMaster = portEn_ff && master_enable_bit_ff; // [R15]
  assign isSlave  = portEn_ff && !master_enable_bit_ff;

  // select pin and master input pass two flops; slave selection uses the raw select pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      selMeta_ff  <= 1'b1;
      selSync_ff  <= 1'b1;
      selPrev_ff  <= 1'b1;
      misoMeta_ff <= 1'b0;
      misoSync_ff <= 1'b0;
    end else begin
      selMeta_ff  <= selIn_n;
      selSync_ff  <= selMeta_ff;
      selPrev_ff  <= selSync_ff;
      misoMeta_ff <= misoIn;
      misoSync_ff <= misoMeta_ff;
    end
  end

  // completion toggle from the serial-clock domain; the chain is cleared with the
  // link, so the toggle's own fall to zero on a deselect is not taken for a byte;
  // a deselect within three clocks of the last latching edge loses that byte
  always_ff @(posedge ref_clk or negedge lnk.lnkRst_n) begin
    if (!lnk.lnkRst_n) begin
      tglMeta_ff <= 1'b0;
      tglSync_ff <= 1'b0;
      tglPrev_ff <= 1'b0;
    end else begin
      tglMeta_ff <= lnk.doneTgl;
      tglSync_ff <= tglMeta_ff;
      tglPrev_ff <= tglSync_ff;
    end
  end

  assign selFall   = selPrev_ff && !selSync_ff;
  assign modeFault = isMaster && (mode_ff == `SPIMS_MODE_MULTI) && selFall; // [R8]
  // rx word in the link domain stays put for seven more edges, long enough to read
  assign slvDone   = (tglSync_ff != tglPrev_ff) && isSlave;

  // control bits; a mode fault wins over a simultaneous write so the bus is freed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_enable_bit_ff  <= 1'b0;
      portEn_ff <= 1'b0; // [R23]
      mode_ff   <= `SPIMS_MODE_RESET; // [R14]
      phase_ff  <= 1'b0;
      pol_ff    <= 1'b0;
    end else if (modeFault) begin
      // stays off until software writes the enables again
      master_enable_bit_ff  <= 1'b0; // [R8] [R10]
      portEn_ff <= 1'b0;
    end else if (ctlWrite) begin
      master_enable_bit_ff  <= ctlMasterEnable;
      portEn_ff <= ctlPortEnable;
      mode_ff   <= ctlSelectMode;
      phase_ff  <= ctlClockPhase; // [R21]
      pol_ff    <= ctlClockPolarity;
    end
  end

  // master half-period bookkeeping
  assign halfEnd   = (mst_ff == SPIMS_RUN) && (div_ff == DIV_LAST);
  // with late phase an extra leading half shifts the bit window by one
  assign kIdx      = half_ff - {4'h0, phase_ff};
  assign mstFinish = halfEnd && (half_ff != 5'h0 || !phase_ff) && kIdx == `SPIMS_LAST_K;
  assign mstStart  = isMaster && (mst_ff == SPIMS_IDLE) && txFull_ff; // [R16]

  // master sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_ff    <= SPIMS_IDLE;
      shift_ff  <= 8'h00; // [R23]
      half_ff   <= 5'h00;
      div_ff    <= '0;
      sckTgl_ff <= 1'b0;
    end else if (!isMaster) begin
      // a fault or disable aborts a byte in flight
      mst_ff    <= SPIMS_IDLE;
      half_ff   <= 5'h00;
      div_ff    <= '0;
      sckTgl_ff <= 1'b0;
    end else begin
      case (mst_ff)
        SPIMS_IDLE: begin
          if (mstStart) begin
            shift_ff <= txBuf_ff; // [R16]
            mst_ff   <= SPIMS_RUN; // [R17]
            half_ff  <= 5'h00;
            div_ff   <= '0;
          end
        end
        SPIMS_RUN: begin
          if (div_ff == DIV_LAST) begin
            div_ff <= '0;
          end else begin
            div_ff <= div_ff + DIV_W'(1);
          end
          if (halfEnd) begin
            half_ff <= half_ff + 5'h01;
            // sixteen serial clock edges per byte, none after the last half
            if (half_ff < 5'h10) begin
              sckTgl_ff <= ~sckTgl_ff; // [R17]
            end
            // sample one system clock before the changing edge, then shift
            if (kIdx[0] && (half_ff != 5'h0 || !phase_ff)) begin
              shift_ff <= {shift_ff[6:0], misoSync_ff}; // [R22] [R1]
            end
            if (mstFinish) begin
              mst_ff <= SPIMS_DONE;
            end
          end
        end
        SPIMS_DONE: begin
          mst_ff    <= SPIMS_IDLE;
          sckTgl_ff <= 1'b0;
        end
        default: begin
          mst_ff <= SPIMS_IDLE;
        end
      endcase
    end
  end

  assign byteDone = (mst_ff == SPIMS_DONE) || slvDone; // [R20]
  assign doneByte = (mst_ff == SPIMS_DONE) ? shift_ff : lnk.rxWord;
  // slave word slot refills from the transmit buffer after each slave byte
  assign txTake   = (mstStart) || (isSlave && txFull_ff && (slvDone || !busy));

  // transmit buffer; a write while still full is dropped and flagged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf_ff  <= 8'h00;
      txFull_ff <= 1'b0; // [R23]
      slvTx_ff  <= 8'h00;
    end else begin
      if (dataWrite && !txFull_ff) begin
        txBuf_ff  <= dataIn; // [R16]
        txFull_ff <= 1'b1;
      end else if (txTake) begin
        txFull_ff <= 1'b0;
      end
      if (txTake && isSlave) begin
        slvTx_ff <= txBuf_ff;
      end
    end
  end

  // receive buffer; overrun keeps the unread byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_ff  <= 8'h00;
      rxFull_ff <= 1'b0;
    end else begin
      if (byteDone && !(rxFull_ff && isSlave)) begin
        rxBuf_ff  <= doneByte; // [R19]
        rxFull_ff <= 1'b1;
      end else if (dataRead) begin
        rxFull_ff <= 1'b0;
      end
    end
  end

  // sticky flags; a set in the same cycle as its clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0; // [R23]
      mode_fault_flag_ff <= 1'b0;
      wcol_ff <= 1'b0;
      ovrn_ff <= 1'b0;
    end else begin
      if (byteDone) begin
        done_ff <= 1'b1; // [R18]
      end else if (clrTransferDone) begin
        done_ff <= 1'b0;
      end
      if (modeFault) begin
        mode_fault_flag_ff <= 1'b1; // [R8]
      end else if (clrModeFault) begin
        mode_fault_flag_ff <= 1'b0;
      end
      if (dataWrite && txFull_ff) begin
        wcol_ff <= 1'b1;
      end else if (clrWriteCollision) begin
        wcol_ff <= 1'b0;
      end
      if (slvDone && rxFull_ff) begin
        ovrn_ff <= 1'b1;
      end else if (clrRxOverrun) begin
        ovrn_ff <= 1'b0;
      end
    end
  end

  // one request line for all four flags
  assign irqReq = irqEnable && (done_ff || mode_fault_flag_ff || wcol_ff || ovrn_ff); // [R9] [R18]

  // slave selection: 3-wire is always selected, mode 01 follows the pin, modes 1x never select
  assign slvSelected = (mode_ff == `SPIMS_MODE_3WIRE) || (mode_ff == `SPIMS_MODE_MULTI && !selIn_n); // [R6] [R7]

  // the link domain is held in reset while this port is not an active slave;
  // the raw pin is used so a deselect clears the bit counter at once
  assign lnk.lnkRst_n = rst_n && isSlave && slvSelected; // [R5]
  // polarity and phase folded so the link samples on rising and shifts on falling
  assign lnk.lnkClk   = sckIn ^ pol_ff ^ phase_ff; // [R21]
  assign lnk.mosiIn   = mosiIn;
  // changes only while the core is not busy or just after a slave byte ends; in 3-wire mode busy needs the select pin low
  assign lnk.txWord   = slvTx_ff;

  spims_slave_shift u_slave (
    .lnk (lnk)
  );

  // serial pins
  assign sckOut   = pol_ff ^ sckTgl_ff; // [R21]
  assign sckOe    = isMaster;
  assign mosiOut  = shift_ff[7]; // [R2]
  assign mosiOe   = isMaster;
  assign misoOut  = lnk.misoBit; // [R4]
  assign misoOe   = isSlave && slvSelected; // [R3]
  // select drives out in modes 1x whenever the port is enabled, level set by the low mode bit
  assign selOut_n = mode_ff[0]; // [R11]
  assign selOe    = portEn_ff && mode_ff[1]; // [R11] [R12]
  assign selPinMapped = (mode_ff != `SPIMS_MODE_3WIRE); // [R13]

  // status view
  assign masterEnableBit    = master_enable_bit_ff;
  assign portEnableBit      = portEn_ff;
  assign selectModeField    = mode_ff;
  assign transferDoneFlag   = done_ff;
  assign modeFaultFlag      = mode_fault_flag_ff;
  assign writeCollisionFlag = wcol_ff;
  assign rxOverrunFlag      = ovrn_ff;
  assign rxData             = rxBuf_ff;
  assign busy               = (mst_ff != SPIMS_IDLE) || (lnk.lnkRst_n && isSlave && slvSelected && !selSync_ff);
endmodule
`default_nettype wire

/* design/spims_defines.svh */
// constants of the serial master/slave port
`ifndef SPIMS_DEFINES_SVH
`define SPIMS_DEFINES_SVH

// select mode field encodings
`define SPIMS_MODE_3WIRE      2'b00
`define SPIMS_MODE_MULTI      2'b01
// reset value of the select mode field: multi-master / 4-wire slave
`define SPIMS_MODE_RESET      2'b01
// bits per byte on the serial lines
`define SPIMS_BITS            4'h8
// last half-period index counted by the master half-period counter
`define SPIMS_LAST_K          5'h0f
// last sampled bit index in the slave bit counter
`define SPIMS_SLV_LAST        3'h7
// default system clocks per half period of the generated serial clock
`define SPIMS_HALF_DIV        1

`endif

/* design/spims_pkg.sv */
// types shared by the serial master/slave port modules
`default_nettype none
package spims_pkg;
  // master sequencer states
  typedef enum logic [1:0] {
    SPIMS_IDLE,
    SPIMS_RUN,
    SPIMS_DONE
  } spims_mst_t;
  typedef logic [7:0] spims_byte_t;
  typedef logic [1:0] spims_mode_t;
endpackage
`default_nettype wire

/* design/spims_lnk_if.sv */
// carrier between the system-clock core and the serial-clock slave shifter
`default_nettype none
interface spims_lnk_if;
  import spims_pkg::*;
  logic        lnkClk;   // serial clock, polarity and phase folded in
  logic        lnkRst_n; // holds the slave shifter idle while unselected
  logic        mosiIn;   // data arriving from the master
  spims_byte_t txWord;   // byte to send, replaced only while the core is not busy or just after a slave byte
  spims_byte_t rxWord;   // last complete byte received
  logic        doneTgl;  // flips once per completed byte
  logic        misoBit;  // bit presented to the master
  modport core (output lnkClk, output lnkRst_n, output mosiIn, output txWord,
                input rxWord, input doneTgl, input misoBit);
  modport link (input lnkClk, input lnkRst_n, input mosiIn, input txWord,
                output rxWord, output doneTgl, output misoBit);
endinterface
`default_nettype wire

/* design/spims_slave_shift.sv */
// slave shift register clocked by the incoming serial clock
`default_nettype none
module spims_slave_shift
  import spims_pkg::*;
(
  spims_lnk_if.link lnk
);
  logic [2:0]  bitCnt_ff;
  logic        sampled_ff;
  logic        loaded_ff;
  spims_byte_t shift_ff;
  spims_byte_t rxWord_ff;
  logic        doneTgl_ff;

  // latching edge: sample the line, count, and close the byte on the eighth
  always_ff @(posedge lnk.lnkClk or negedge lnk.lnkRst_n) begin
    if (!lnk.lnkRst_n) begin
      bitCnt_ff  <= 3'h0;
      sampled_ff <= 1'b0;
      rxWord_ff  <= 8'h00;
      doneTgl_ff <= 1'b0;
    end else begin
      sampled_ff <= lnk.mosiIn;
      bitCnt_ff  <= bitCnt_ff + 3'h1;
      if (bitCnt_ff == `SPIMS_SLV_LAST) begin // [R20]
        // msb arrived first, this bit is the lsb
        rxWord_ff  <= {(loaded_ff ? shift_ff[6:0] : lnk.txWord[6:0]), lnk.mosiIn}; // [R1]
        doneTgl_ff <= ~doneTgl_ff;
      end
    end
  end

  // changing edge: load a fresh byte at a byte boundary, else shift left
  always_ff @(negedge lnk.lnkClk or negedge lnk.lnkRst_n) begin
    if (!lnk.lnkRst_n) begin
      shift_ff  <= 8'h00;
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
      if (bitCnt_ff == 3'h0) begin
        shift_ff <= lnk.txWord;
      end else begin
        shift_ff <= {(loaded_ff ? shift_ff[6:0] : lnk.txWord[6:0]), sampled_ff}; // [R1]
      end
    end
  end

  // until the first changing edge the pending byte's msb is on the line
  assign lnk.misoBit = loaded_ff ? shift_ff[7] : lnk.txWord[7]; // [R4]
  assign lnk.rxWord  = rxWord_ff;
  assign lnk.doneTgl = doneTgl_ff;
endmodule
`default_nettype wire

/* tb/spims_port_assertions.sv */
// concurrent checks on the serial port's pins and flags
`default_nettype none
module spims_port_assertions #(
  parameter int HALF_DIV = 1
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       ctlWrite,
  input wire logic       irqEnable,
  input wire logic       dataWrite,
  input wire logic       selIn_n,
  input wire logic       masterEnableBit,
  input wire logic       portEnableBit,
  input wire logic [1:0] selectModeField,
  input wire logic       transferDoneFlag,
  input wire logic       modeFaultFlag,
  input wire logic       writeCollisionFlag,
  input wire logic       rxOverrunFlag,
  input wire logic       busy,
  input wire logic       irqReq,
  input wire logic       sckOut,
  input wire logic       sckOe,
  input wire logic       misoOe,
  input wire logic       mosiOe,
  input wire logic       selOut_n,
  input wire logic       selOe,
  input wire logic       selPinMapped
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] edgeCnt_ff;
  logic       sckPrev_ff;
  // generated clock edges per run; restarts when the sequencer leaves idle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt_ff <= 5'h00;
      sckPrev_ff <= 1'b0;
    end else begin
      sckPrev_ff <= sckOut;
      if (busy && !$past(busy))
        edgeCnt_ff <= 5'h00;
      else if (sckOe && sckOut != sckPrev_ff)
        edgeCnt_ff <= edgeCnt_ff + 5'h01;
    end
  end
  // current edge added in, since the flag may land with the last edge
  done_count_a: assert property ($rose(transferDoneFlag) && masterEnableBit |->
    edgeCnt_ff + 5'(sckOut != sckPrev_ff) == 5'h10) else $error("done without sixteen edges");
  collide_flag_a: assert property (dataWrite && $past(dataWrite) && masterEnableBit |=>
    writeCollisionFlag) else $error("write into full buffer not flagged");
  fault_off_a: assert property ($rose(modeFaultFlag) |-> !masterEnableBit && !portEnableBit)
    else $error("fault left port enabled");
  no_restore_a: assert property (!masterEnableBit && !ctlWrite |=> !masterEnableBit)
    else $error("master role came back by itself");
  irq_gate_a: assert property (irqReq == (irqEnable && (transferDoneFlag || modeFaultFlag
    || writeCollisionFlag || rxOverrunFlag))) else $error("interrupt request wrong");
  sel_out_a: assert property (portEnableBit && selectModeField[1] |->
    selOe && selOut_n == selectModeField[0]) else $error("select output wrong");
  sel_map_a: assert property (selPinMapped == (selectModeField != 2'b00))
    else $error("select pin routing wrong");
  miso_off_a: assert property (!portEnableBit && !$past(portEnableBit) |-> !misoOe)
    else $error("data out driven while disabled");
  miso_3wire_a: assert property (portEnableBit && $past(portEnableBit) && !masterEnableBit
    && !$past(masterEnableBit) && selectModeField == 2'b00 && $past(selectModeField) == 2'b00
    |-> misoOe) else $error("3-wire slave not driving");
  unsel_quiet_a: assert property (selIn_n [*4] ##0 (portEnableBit && !masterEnableBit
    && selectModeField == 2'b01 && $past(selectModeField) == 2'b01) |-> !misoOe)
    else $error("unselected slave driving");
  reset_state_a: assert property ($rose(rst_n) |-> selectModeField == 2'b01
    && !modeFaultFlag && !transferDoneFlag && !mosiOe && !sckOe) else $error("state after reset");
  cover property ($rose(transferDoneFlag) && masterEnableBit);
  cover property ($rose(transferDoneFlag) && !masterEnableBit);
  cover property ($rose(modeFaultFlag));
  cover property ($rose(writeCollisionFlag));
endmodule
bind spims_port spims_port_assertions #(.HALF_DIV(HALF_DIV)) i_spims_port_assertions (
  .ref_clk, .rst_n, .ctlWrite, .irqEnable, .dataWrite, .selIn_n, .masterEnableBit,
  .portEnableBit, .selectModeField, .transferDoneFlag, .modeFaultFlag, .writeCollisionFlag,
  .rxOverrunFlag, .busy, .irqReq, .sckOut, .sckOe, .misoOe, .mosiOe, .selOut_n, .selOe, .selPinMapped);
`default_nettype wire

/* tb/spims_partner.sv */
// far-side device: slave to the port as master, master to it as slave
`default_nettype none
module spims_partner (
  input  wire logic sckLine,
  input  wire logic mosiLine,
  input  wire logic misoLine,
  input  wire logic pol,
  input  wire logic pha,
  output logic      pSck,
  output logic      pMosi,
  output logic      pMiso,
  output logic      pSel_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] txS = 8'h00;
  logic [7:0] rxS = 8'h00;
  int         cnt = 0;
  wire logic  lat = sckLine ^ pol ^ pha;
  initial begin
    pSck = 1'b0;
    pMosi = 1'b0;
    pSel_n = 1'b1;
  end
  assign pMiso = txS[7];
  // latch on the active edge, msb first
  always @(posedge lat) begin
    rxS = {rxS[6:0], mosiLine};
    cnt++;
  end
  // change on the other edge; in phase 1 the first one comes before any latch
  always @(negedge lat)
    if (cnt != 0)
      txS = {txS[6:0], ~txS[0]};
  task load(input logic [7:0] b);
    txS = b;
    cnt = 0;
  endtask
  // one bit per 125 ns; the clock stands still outside the frame
  task send(input logic [7:0] mo, input logic sel, output logic [7:0] mi);
    pSel_n = !sel;
    #317;
    for (int i = 7; i >= 0; i--) begin
      pMosi = mo[i];
      #62.5;
      pSck = 1'b1;
      mi[i] = misoLine;
      #62.5;
      pSck = 1'b0;
    end
    pMosi = ~pMosi;
    #300;
    pSel_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// bench: serial port against a far-side device
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       rst_n;
  logic       ctlWrite = 1'b0, ctlMasterEnable = 1'b0, ctlPortEnable = 1'b0;
  logic       ctlClockPhase = 1'b0, ctlClockPolarity = 1'b0, irqEnable = 1'b0;
  logic [1:0] ctlSelectMode = 2'b01;
  logic       dataWrite = 1'b0, dataRead = 1'b0, clrTransferDone = 1'b0;
  logic       clrModeFault = 1'b0, clrWriteCollision = 1'b0;
  logic [7:0] dataIn = 8'h00;
  int         n_errors = 0, checked = 0;
  wire logic [7:0] rxData;
  wire logic  masterEnableBit, portEnableBit, transferDoneFlag, modeFaultFlag;
  wire logic  writeCollisionFlag, rxOverrunFlag, busy, irqReq, sckOut, sckOe, mosiOut, mosiOe;
  wire logic  misoOut, misoOe, selOut_n, selOe, selPinMapped, pSck, pMosi, pMiso, pSel_n;
  wire logic [1:0] selectModeField;
  // pin levels from the port's enables, far side driving otherwise
  wire logic  sckLine = sckOe ? sckOut : pSck;
  wire logic  mosiLine = mosiOe ? mosiOut : pMosi;
  wire logic  misoLine = misoOe ? misoOut : pMiso;
  wire logic  selLine = selOe ? selOut_n : pSel_n;
  spims_port #(.HALF_DIV(2)) i_spims_port (.ref_clk, .rst_n, .ctlWrite, .ctlMasterEnable,
    .ctlPortEnable, .ctlSelectMode, .ctlClockPhase, .ctlClockPolarity, .irqEnable, .dataWrite,
    .dataIn, .dataRead, .rxData, .clrTransferDone, .clrModeFault, .clrWriteCollision,
    .clrRxOverrun(1'b0), .masterEnableBit, .portEnableBit, .selectModeField, .transferDoneFlag,
    .modeFaultFlag, .writeCollisionFlag, .rxOverrunFlag, .busy, .irqReq, .sckIn(sckLine), .sckOut,
    .sckOe, .mosiIn(mosiLine), .mosiOut, .mosiOe, .misoIn(misoLine), .misoOut, .misoOe,
    .selIn_n(selLine), .selOut_n, .selOe, .selPinMapped);
  spims_partner i_spims_partner (.sckLine, .mosiLine, .misoLine, .pol(ctlClockPolarity),
    .pha(ctlClockPhase), .pSck, .pMosi, .pMiso, .pSel_n);
  always #50 ref_clk = ~ref_clk;
  task tick();
    @(posedge ref_clk);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ctl(input logic me, input logic pe, input logic [1:0] md, input logic ph, input logic po);
    ctlMasterEnable = me;
    ctlPortEnable = pe;
    ctlSelectMode = md;
    ctlClockPhase = ph;
    ctlClockPolarity = po;
    pulse(ctlWrite);
    tick();
    tick();
  endtask
  // bounded wait for end of byte, then read and clear
  task wait_done();
    for (int n = 0; n < 300 && transferDoneFlag !== 1'b1; n++)
      tick();
    chk1("transferDoneFlag", 1'b1, transferDoneFlag);
    chk1("irqReq", irqEnable, irqReq);
    pulse(dataRead);
    pulse(clrTransferDone);
  endtask
  task t_modes();
    for (int m = 0; m < 4; m++) begin
      ctl(1'b1, 1'b1, m[1:0], 1'b0, 1'b0);
      chk1("selPinMapped", m != 0, selPinMapped);
      chk1("selOe", m[1], selOe);
      if (m[1])
        chk1("selOut_n", m[0], selOut_n);
    end
  endtask
  task t_master(input logic [1:0] md, input logic ph, input logic po, input logic [7:0] tx);
    ctl(1'b1, 1'b1, md, ph, po);
    chk1("sckOut idle", po, sckOut);
    i_spims_partner.load(~tx);
    dataIn = tx;
    pulse(dataWrite);
    wait_done();
    chk8("rxData", ~tx, rxData);
    chk8("far side rx", tx, i_spims_partner.rxS);
    chk1("busy", 1'b0, busy);
  endtask
  task t_coll();
    ctl(1'b1, 1'b1, 2'b11, 1'b0, 1'b0);
    i_spims_partner.load(8'h5a);
    dataIn = 8'hc3;
    dataWrite = 1'b1;
    tick();
    dataIn = 8'h3c;
    tick();
    dataWrite = 1'b0;
    chk1("writeCollisionFlag", 1'b1, writeCollisionFlag);
    wait_done();
    chk8("far side rx", 8'hc3, i_spims_partner.rxS);
    pulse(clrWriteCollision);
  endtask
  task t_fault();
    irqEnable = 1'b1;
    ctl(1'b1, 1'b1, 2'b01, 1'b0, 1'b0);
    i_spims_partner.pSel_n = 1'b0;
    repeat (6) tick();
    chk1("modeFaultFlag", 1'b1, modeFaultFlag);
    chk1("enables", 1'b0, masterEnableBit | portEnableBit);
    chk1("irqReq", 1'b1, irqReq);
    i_spims_partner.pSel_n = 1'b1;
    repeat (6) tick();
    chk1("masterEnableBit", 1'b0, masterEnableBit);
    pulse(clrModeFault);
  endtask
  // slave byte; in mode 01 a clock burst while unselected comes first
  task t_slave(input logic [1:0] md, input logic [7:0] tx, input logic [7:0] mo);
    logic [7:0] mi;
    ctl(1'b0, 1'b0, md, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, md, 1'b0, 1'b0);
    dataIn = tx;
    pulse(dataWrite);
    tick();
    chk1("misoOe", md == 2'b00, misoOe);
    if (md == 2'b01)
      i_spims_partner.send(8'h00, 1'b0, mi);
    i_spims_partner.send(mo, md == 2'b01, mi);
    chk8("far side rx", tx, mi);
    wait_done();
    chk8("rxData", mo, rxData);
    repeat (4) tick();
    chk1("transferDoneFlag", 1'b0, transferDoneFlag);
    chk1("rxOverrunFlag", 1'b0, rxOverrunFlag);
  endtask
  task stop_test();
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    tick();
    chk8("selectModeField", 8'h01, {6'h00, selectModeField});
    chk1("flags", 1'b0, transferDoneFlag | modeFaultFlag | writeCollisionFlag);
    chk1("enables", 1'b0, sckOe | mosiOe | misoOe | portEnableBit);
    t_modes();
    for (int i = 0; i < 4; i++) begin
      irqEnable = i[0];
      t_master(i[1:0], i[0], i[1], 8'h81 ^ i[7:0]);
    end
    t_coll();
    t_fault();
    t_slave(2'b01, 8'h96, 8'ha5);
    t_slave(2'b00, 8'h3b, 8'h4e);
    stop_test();
  end
endmodule
`default_nettype wire
